/* rtl/csms_gfmux.v */
// Glitch-free four-way clock multiplexer for level-modelled clocks
`default_nettype none
`include "csms_map.vh"
module csms_gfmux (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Sources and selection
  input wire [3:0] src,
  input wire [1:0] sel,
  // Selected clock
  output reg clk_q
);
  reg [1:0] cur_q;
  reg [1:0] cur_d;
  reg clk_d;

  // Hand over only while both old and new clock are low, so that
  // no high pulse is ever cut short; a low phase may stretch.
  always @* begin
    cur_d = cur_q;
    if (sel != cur_q && !clk_q && !src[sel]) begin
      cur_d = sel;
    end
    clk_d = src[cur_d];
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= 2'h0;
      clk_q <= 1'b0;
    end else begin
      cur_q <= cur_d;
      clk_q <= clk_d;
    end
  end
endmodule
`default_nettype wire

/* rtl/csms_map.vh */
// Register map, field positions, reset values and timing counts
`ifndef CSMS_MAP_VH
`define CSMS_MAP_VH

`define CSMS_ADDR_OSC_CTRL 8'hB2
`define CSMS_ADDR_TRIM 8'hB3
`define CSMS_ADDR_MULT 8'hB9
`define CSMS_ADDR_LF 8'hE3
`define CSMS_ADDR_SEL 8'hA9

`define CSMS_BIT_OSC_EN 7
`define CSMS_BIT_OSC_RDY 6
`define CSMS_BIT_LF_EN 7
`define CSMS_BIT_MUL_EN 7
`define CSMS_BIT_MUL_INIT 6
`define CSMS_BIT_MUL_LOCK 5
`define CSMS_BIT_MUL_SEL 0

`define CSMS_TRIM_RST 5'h10
`define CSMS_OSC_EN_RST 1'b1
`define CSMS_DIV_RST 2'h0
`define CSMS_SYS_RST 3'h0
`define CSMS_USB_RST 2'h0

`define CSMS_SYS_INT 2'h0
`define CSMS_SYS_EXT 2'h1
`define CSMS_SYS_MULT 2'h2
`define CSMS_SYS_LF 2'h3
`define CSMS_USB_MULT 2'h0
`define CSMS_USB_INT2 2'h1
`define CSMS_USB_EXT 2'h2
`define CSMS_USB_OFF 2'h3

`define CSMS_OSC_HALF_BASE 6'h08
`define CSMS_CLK_KHZ 100000
`define CSMS_LF_KHZ 88
`define CSMS_LF_HALF ((`CSMS_CLK_KHZ) / (2 * (`CSMS_LF_KHZ)))
`define CSMS_LOCK_MATCHES 3'h4

`endif

/* rtl/csms_mult.v */
// Four-times clock multiplier model with init and lock detection
`default_nettype none
`include "csms_map.vh"
module csms_mult (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Control
  input wire in_clk,
  input wire enable,
  input wire start,
  // Status and outputs
  output reg locked_q,
  output reg out_q,
  output reg half_q
);
  reg in_d_q;
  reg run_q;
  reg [7:0] per_cnt_q;
  reg [7:0] per_q;
  reg [2:0] match_q;
  reg [4:0] out_cnt_q;
  wire rise = in_clk & ~in_d_q;
  wire [7:0] measured = (per_cnt_q == 8'hFF) ? 8'hFF : per_cnt_q + 8'h01;
  // Output half period is an eighth of the input period
  wire [4:0] ohalf = (per_q[7:3] == 5'h00) ? 5'h01 : per_q[7:3];

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_d_q <= 1'b0;
      run_q <= 1'b0;
      per_cnt_q <= 8'h00;
      per_q <= 8'h00;
      match_q <= 3'h0;
      locked_q <= 1'b0;
      out_cnt_q <= 5'h00;
      out_q <= 1'b0;
      half_q <= 1'b0;
    end else if (!enable) begin
      // Disable drops lock until a fresh init completes
      in_d_q <= in_clk;
      run_q <= 1'b0;
      per_cnt_q <= 8'h00;
      match_q <= 3'h0;
      locked_q <= 1'b0;
      out_cnt_q <= 5'h00;
      out_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      in_d_q <= in_clk;
      if (start) begin
        run_q <= 1'b1;
        per_cnt_q <= 8'h00;
        match_q <= 3'h0;
        locked_q <= 1'b0;
      end else if (run_q) begin
        if (rise) begin
          per_cnt_q <= 8'h00;
          per_q <= measured;
          if (measured == per_q) begin
            if (match_q == `CSMS_LOCK_MATCHES - 3'h1) begin
              locked_q <= 1'b1;
            end else begin
              match_q <= match_q + 3'h1;
            end
          end else begin
            match_q <= 3'h0;
            locked_q <= 1'b0;
          end
        end else if (per_cnt_q != 8'hFF) begin
          per_cnt_q <= per_cnt_q + 8'h01;
        end
      end
      // Output only runs once locked; before that it is unusable
      if (locked_q) begin
        if (out_cnt_q >= ohalf - 5'h01) begin
          out_cnt_q <= 5'h00;
          out_q <= ~out_q;
          if (!out_q) begin
            half_q <= ~half_q;
          end
        end else begin
          out_cnt_q <= out_cnt_q + 5'h01;
        end
      end else begin
        out_cnt_q <= 5'h00;
        out_q <= 1'b0;
        half_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/csms_top.v */
// Clock source, multiplier and clock select unit with its registers
`default_nettype none
`include "csms_map.vh"
module csms_top (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Special function register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  // External clock pin and port control
  input wire ext_clock_pin,
  input wire global_input_enable,
  // Clock recovery
  input wire clk_recovery_en,
  input wire [4:0] recovery_trim,
  // Clock outputs
  output wire sys_clk_out,
  output wire usb_clk_out,
  output reg ext_periph_clk
);
  // Terminal test shared by the oscillator counters
  function csms_term;
    input [9:0] cnt;
    input [9:0] half;
    begin
      csms_term = (cnt >= half - 10'h001);
    end
  endfunction

  // Internal oscillator divide pick
  function csms_div_pick;
    input [1:0] code;
    input [2:0] cnt;
    input osc;
    begin
      case (code)
        2'h0: csms_div_pick = cnt[2];
        2'h1: csms_div_pick = cnt[1];
        2'h2: csms_div_pick = cnt[0];
        default: csms_div_pick = osc;
      endcase
    end
  endfunction

  // Address match shared by every write strobe
  function csms_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      csms_hit = (addr == target);
    end
  endfunction

  // Reset release synchroniser
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n = rst_sync_q;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Register strobes
  wire wr_osc = sfr_wr && csms_hit(sfr_addr, `CSMS_ADDR_OSC_CTRL);
  wire wr_trim = sfr_wr && csms_hit(sfr_addr, `CSMS_ADDR_TRIM);
  wire wr_mult = sfr_wr && csms_hit(sfr_addr, `CSMS_ADDR_MULT);
  wire wr_lf = sfr_wr && csms_hit(sfr_addr, `CSMS_ADDR_LF);
  wire wr_sel = sfr_wr && csms_hit(sfr_addr, `CSMS_ADDR_SEL);

  // Write data fields; bits without a field are dropped here
  wire wd_osc_en = sfr_wdata[`CSMS_BIT_OSC_EN];
  wire [1:0] wd_div = sfr_wdata[1:0];
  wire [4:0] wd_trim = sfr_wdata[4:0];
  wire wd_lf_en = sfr_wdata[`CSMS_BIT_LF_EN];
  wire wd_mul_en = sfr_wdata[`CSMS_BIT_MUL_EN];
  wire wd_mul_init = sfr_wdata[`CSMS_BIT_MUL_INIT];
  wire wd_mul_sel = sfr_wdata[`CSMS_BIT_MUL_SEL];
  wire [1:0] wd_usb = sfr_wdata[5:4];
  wire [2:0] wd_sys = sfr_wdata[2:0];
  // Reserved system codes all have the top bit set
  wire wd_sys_ok = !sfr_wdata[2];

  // Control registers
  reg osc_en_q;
  reg [1:0] osc_div_q;
  reg [4:0] trim_q;
  reg lf_en_q;
  reg mul_en_q;
  reg mul_init_q;
  reg mul_sel_q;
  reg [1:0] usb_src_q;
  reg [2:0] sys_src_q;
  // Status comes straight from the multiplier's lock flop
  wire mul_locked;

  // Init only counts when enable was already set before this write
  wire mul_start = wr_mult && wd_mul_init && wd_mul_en && mul_en_q &&
                   !mul_init_q;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_en_q <= `CSMS_OSC_EN_RST;
      osc_div_q <= `CSMS_DIV_RST;
    end else if (wr_osc) begin
      osc_en_q <= wd_osc_en;
      osc_div_q <= wd_div;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_q <= `CSMS_TRIM_RST;
    end else if (clk_recovery_en) begin
      // Recovery owns the trim, so software writes are ignored
      trim_q <= recovery_trim;
    end else if (wr_trim) begin
      trim_q <= wd_trim;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lf_en_q <= 1'b0;
    end else if (wr_lf) begin
      lf_en_q <= wd_lf_en;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mul_en_q <= 1'b0;
      mul_init_q <= 1'b0;
      mul_sel_q <= 1'b0;
    end else if (wr_mult) begin
      mul_en_q <= wd_mul_en;
      mul_init_q <= wd_mul_init;
      mul_sel_q <= wd_mul_sel;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      usb_src_q <= `CSMS_USB_RST;
      sys_src_q <= `CSMS_SYS_RST;
    end else if (wr_sel) begin
      usb_src_q <= wd_usb;
      // Reserved system codes are refused, keeping the running source
      if (wd_sys_ok) begin
        sys_src_q <= wd_sys;
      end
    end
  end

  // Internal oscillator: half period grows with the trim value
  reg [5:0] osc_cnt_q;
  reg osc_q;
  reg [2:0] div_cnt_q;
  wire [5:0] osc_half = `CSMS_OSC_HALF_BASE + {1'b0, trim_q};
  wire osc_term = csms_term({4'h0, osc_cnt_q}, {4'h0, osc_half});

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_q <= 6'h00;
      osc_q <= 1'b0;
      div_cnt_q <= 3'h0;
    end else if (!osc_en_q) begin
      osc_cnt_q <= 6'h00;
      osc_q <= 1'b0;
      div_cnt_q <= 3'h0;
    end else if (osc_term) begin
      // First toggle comes osc_half cycles after the enabling write
      osc_cnt_q <= 6'h00;
      osc_q <= ~osc_q;
      if (!osc_q) begin
        div_cnt_q <= div_cnt_q + 3'h1;
      end
    end else begin
      osc_cnt_q <= osc_cnt_q + 6'h01;
    end
  end

  // Codes 0 to 2 tap counter bits and code 3 the oscillator, so all ratios share one phase
  wire int_sys = csms_div_pick(osc_div_q, div_cnt_q, osc_q);
  wire int_half = div_cnt_q[0];

  // Low-frequency oscillator
  reg [9:0] lf_cnt_q;
  reg lf_q;
  // Count is worked out at integer width, then cut to the counter
  localparam [31:0] lf_half_full = `CSMS_LF_HALF;
  wire [9:0] lf_half = lf_half_full[9:0];

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lf_cnt_q <= 10'h000;
      lf_q <= 1'b0;
    end else if (!lf_en_q) begin
      lf_cnt_q <= 10'h000;
      lf_q <= 1'b0;
    end else if (csms_term(lf_cnt_q, lf_half)) begin
      lf_cnt_q <= 10'h000;
      lf_q <= ~lf_q;
    end else begin
      lf_cnt_q <= lf_cnt_q + 10'h001;
    end
  end

  // External clock: only seen once the port input path is enabled
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_periph_clk <= 1'b0;
    end else begin
      ext_periph_clk <= ext_clock_pin & global_input_enable;
    end
  end

  // Peripherals keep the external clock whatever the system source
  wire ext_clk = ext_periph_clk;

  // Multiplier
  // Change the input only while the multiplier is off
  wire mul_in = mul_sel_q ? ext_clk : osc_q;
  wire mul_out;
  wire mul_half;

  // Lock is lost as soon as enable drops
  csms_mult u_mult (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_clk(mul_in),
    .enable(mul_en_q),
    .start(mul_start),
    .locked_q(mul_locked),
    .out_q(mul_out),
    .half_q(mul_half)
  );

  // System and USB clock multiplexers
  // Bit order follows the select codes; USB code 11 is held low
  wire [3:0] sys_srcs = {lf_q, mul_half, ext_clk, int_sys};
  wire [3:0] usb_srcs = {1'b0, ext_clk, int_half, mul_out};
  // Refused codes never leave the stored top bit set
  wire [1:0] sys_sel = sys_src_q[1:0];

  // Reset selects code zero, the internal oscillator
  csms_gfmux u_sys_mux (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .src(sys_srcs),
    .sel(sys_sel),
    .clk_q(sys_clk_out)
  );

  // Stopping the USB clock is a switch to the tied-low input
  csms_gfmux u_usb_mux (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .src(usb_srcs),
    .sel(usb_src_q),
    .clk_q(usb_clk_out)
  );

  // Read data, one cycle after the read strobe
  reg [7:0] rd_d;

  always @* begin
    if (sfr_addr == `CSMS_ADDR_OSC_CTRL) begin
      rd_d = {osc_en_q, osc_en_q, 4'h0, osc_div_q};
    end else if (sfr_addr == `CSMS_ADDR_TRIM) begin
      rd_d = {3'h0, trim_q};
    end else if (sfr_addr == `CSMS_ADDR_MULT) begin
      rd_d = {mul_en_q, mul_init_q, mul_locked, 4'h0,
              mul_sel_q};
    end else if (sfr_addr == `CSMS_ADDR_LF) begin
      rd_d = {lf_en_q, 7'h00};
    end else if (sfr_addr == `CSMS_ADDR_SEL) begin
      rd_d = {2'h0, usb_src_q, 1'b0, sys_src_q};
    end else begin
      rd_d = 8'h00;
    end
  end

  // Held between reads, so a late sample still sees it
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= rd_d;
    end
  end
endmodule
`default_nettype wire

/* tb/csms_monitor.sv */
// Checker for the clock source unit register and clock ports
`default_nettype none
module csms_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Clock pins and outputs
  input wire logic ext_clock_pin,
  input wire logic global_input_enable,
  input wire logic clk_recovery_en,
  input wire logic [4:0] recovery_trim,
  input wire logic usb_clk_out,
  input wire logic ext_periph_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] sys_q;
  logic [1:0] usb_q;
  logic [4:0] trim_q;
  logic [7:0] off_q;
  logic [1:0] up_q;
  wire logic rd_a = sfr_rd && sfr_addr == 8'hA9;
  wire logic rd_m = sfr_rd && sfr_addr == 8'hB9;
  wire logic wr_m = sfr_wr && sfr_addr == 8'hB9;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Shadow of writable fields, refused codes left out
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sys_q <= 3'h0;
      usb_q <= 2'h0;
      trim_q <= 5'h10;
      off_q <= 8'h00;
      up_q <= 2'h0;
    end else begin
      if (sfr_wr && sfr_addr == 8'hA9) begin
        usb_q <= sfr_wdata[5:4];
        if (!sfr_wdata[2]) sys_q <= sfr_wdata[2:0];
      end
      if (clk_recovery_en) trim_q <= recovery_trim;
      else if (sfr_wr && sfr_addr == 8'hB3) trim_q <= sfr_wdata[4:0];
      off_q <= usb_q != 2'h3 ? 8'h00 : off_q + {7'h0, off_q != 8'hFF};
      up_q <= up_q + {1'b0, up_q != 2'h3};
    end
  end
  property p_lf;
    sfr_rd && sfr_addr == 8'hE3 |=> sfr_rdata[6:0] == 7'h00;
  endproperty
  a_lf: assert property (p_lf) else $error("lf bits not zero");
  property p_mul;
    rd_m |=> sfr_rdata[4:1] == 4'h0;
  endproperty
  a_mul: assert property (p_mul) else $error("mult bits not zero");
  property p_trim;
    sfr_rd && sfr_addr == 8'hB3 && !clk_recovery_en
      |=> sfr_rdata == {3'h0, $past(trim_q)};
  endproperty
  a_trim: assert property (p_trim) else $error("trim readback");
  property p_sel;
    rd_a |=> sfr_rdata == {2'h0, $past(usb_q), 1'b0, $past(sys_q)};
  endproperty
  a_sel: assert property (p_sel) else $error("select readback");
  property p_rdy;
    sfr_rd && sfr_addr == 8'hB2 |=> sfr_rdata[6] == sfr_rdata[7];
  endproperty
  a_rdy: assert property (p_rdy) else $error("osc ready lags");
  property p_ext;
    up_q == 2'h3 |-> ext_periph_clk == $past(ext_clock_pin
      && global_input_enable);
  endproperty
  a_ext: assert property (p_ext) else $error("ext clock path");
  property p_lock;
    (wr_m && !sfr_wdata[7]) ##1 (!wr_m)[*2] ##1 rd_m
      |=> sfr_rdata[7:5] == 3'h0;
  endproperty
  a_lock: assert property (p_lock) else $error("lock kept");
  property p_off;
    off_q > 8'hC7 |-> !usb_clk_out;
  endproperty
  a_off: assert property (p_off) else $error("usb clock runs");
  c_lock: cover property (rd_m ##1 sfr_rdata[5]);
  c_off: cover property (off_q == 8'hFF);
  c_lf: cover property (sfr_rd && sfr_addr == 8'hE3 ##1 sfr_rdata[7]);
endmodule
bind csms_top csms_monitor u_mon (.core_clk(core_clk), .rstn(rstn),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .ext_clock_pin(ext_clock_pin), .global_input_enable(global_input_enable),
  .clk_recovery_en(clk_recovery_en), .recovery_trim(recovery_trim),
  .usb_clk_out(usb_clk_out), .ext_periph_clk(ext_periph_clk));
`default_nettype wire

/* tb/csms_top_test.sv */
// Self-checking bench for the clock source unit
`default_nettype none
module csms_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic ext_clock_pin = 1'b0;
  logic global_input_enable = 1'b1;
  logic clk_recovery_en = 1'b0;
  logic [4:0] recovery_trim = 5'h00;
  wire [7:0] sfr_rdata;
  wire sys_clk_out;
  wire usb_clk_out;
  wire ext_periph_clk;
  logic [31:0] seed = 32'h14094C15;
  logic [2:0] ext_cnt = 3'h0;
  logic [7:0] v;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t;
  int k;
  csms_top DUT (.core_clk(core_clk), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .ext_clock_pin(ext_clock_pin),
    .global_input_enable(global_input_enable),
    .clk_recovery_en(clk_recovery_en), .recovery_trim(recovery_trim),
    .sys_clk_out(sys_clk_out), .usb_clk_out(usb_clk_out),
    .ext_periph_clk(ext_periph_clk));
  always #5 core_clk = ~core_clk;
  // External clock of period 8, plus the hang guard
  always @(posedge core_clk) begin
    #1;
    ext_cnt = ext_cnt + 3'h1;
    ext_clock_pin = ext_cnt[2];
    cyc++;
    if (cyc > 40000) begin
      bad_count++;
      stop_test();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Oscillator half period is 8 + trim, scaled by the divider
  function automatic int half_exp(input int tr, input int c);
    return (8 + tr) << (3 - c);
  endfunction
  function automatic logic o(input int u);
    return u == 0 ? sys_clk_out : u == 1 ? usb_clk_out : ext_periph_clk;
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge core_clk) #1;
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge core_clk) #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge core_clk) #1;
    sfr_rd = 1'b0;
    q = sfr_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    chk({8'h00, q}, {8'h00, e});
  endtask
  // Counts high cycles over a window of n cycles
  task automatic cnt_hi(input int u, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge core_clk) #1;
      if (o(u) === 1'b1) c++;
    end
  endtask
  // Skips two pulses, since a switch may stretch the first
  task automatic meas(input int u, input int e);
    int c;
    c = 0;
    repeat (3) begin
      while (o(u) !== 1'b1) @(posedge core_clk) #1;
      c = 0;
      while (o(u) === 1'b1) begin
        c++;
        @(posedge core_clk) #1;
      end
    end
    chk(c[15:0], e[15:0]);
  endtask
  task automatic do_reset;
    rstn = 1'b0;
    repeat (4) @(posedge core_clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge core_clk);
    rdc(8'hB2, 8'hC0);
    rdc(8'hB3, 8'h10);
    rdc(8'hB9, 8'h00);
    rdc(8'hE3, 8'h00);
    rdc(8'hA9, 8'h00);
  endtask
  initial begin
    do_reset();
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      t = i == 0 ? int'(seed[4:0]) : i == 1 ? 31 : 0;
      wr(8'hB3, {3'h7, t[4:0]});
      rdc(8'hB3, {3'h0, t[4:0]});
      for (int c = 0; c < 4; c++) begin
        wr(8'hB2, 8'h80 | c[7:0]);
        rdc(8'hB2, 8'hC0 | c[7:0]);
        meas(0, half_exp(t, c));
      end
      wr(8'hA9, 8'h10);
      meas(1, 2 * (8 + t));
    end
    wr(8'hB2, 8'h03);
    rdc(8'hB2, 8'h03);
    wr(8'hB2, 8'h83);
    meas(0, 8);
    wr(8'hA9, 8'h01);
    meas(0, 4);
    wr(8'hA9, 8'h21);
    meas(1, 4);
    for (int r = 4; r < 8; r++) begin
      seed = xs(seed);
      wr(8'hA9, {seed[7:3], r[2:0]});
      rdc(8'hA9, {2'h0, seed[5:4], 4'h1});
    end
    wr(8'hE3, 8'hFF);
    rdc(8'hE3, 8'h80);
    wr(8'hA9, 8'h03);
    meas(0, 568);
    wr(8'hE3, 8'h00);
    repeat (3) @(posedge core_clk);
    cnt_hi(0, 1200, k);
    chk(k[15:0], 16'h0000);
    wr(8'hA9, 8'h30);
    repeat (200) @(posedge core_clk);
    cnt_hi(1, 100, k);
    chk(k[15:0], 16'h0000);
    wr(8'hB9, 8'h1E);
    rdc(8'hB9, 8'h00);
    wr(8'hB9, 8'hC0);
    repeat (300) @(posedge core_clk);
    rd(8'hB9, v);
    chk({8'h00, v & 8'h20}, 16'h0000);
    for (int s = 0; s < 2; s++) begin
      clk_recovery_en = s == 0;
      wr(8'hB9, 8'h00);
      wr(8'hB9, s[7:0]);
      wr(8'hB9, 8'h80 | s[7:0]);
      repeat (10) @(posedge core_clk);
      wr(8'hB9, 8'hC0 | s[7:0]);
      v = 8'h00;
      for (int j = 0; j < 100 && !v[5]; j++) rd(8'hB9, v);
      chk({8'h00, v}, {8'h00, 8'hE0 | s[7:0]});
      wr(8'hA9, 8'h00);
      meas(1, s == 0 ? 2 : 1);
      wr(8'hA9, 8'h02);
      meas(0, s == 0 ? 4 : 2);
      wr(8'hB9, 8'h00);
      repeat (2) @(posedge core_clk);
      rdc(8'hB9, 8'h00);
    end
    seed = xs(seed);
    recovery_trim = seed[4:0];
    clk_recovery_en = 1'b1;
    wr(8'hB3, ~{3'h0, seed[4:0]});
    clk_recovery_en = 1'b0;
    rdc(8'hB3, {3'h0, seed[4:0]});
    do_reset();
    global_input_enable = 1'b0;
    cnt_hi(2, 16, k);
    chk(k[15:0], 16'h0000);
    global_input_enable = 1'b1;
    @(posedge core_clk) #1;
    cnt_hi(2, 16, k);
    chk(k[15:0], 16'h0008);
    stop_test();
  end
endmodule
`default_nettype wire
